// file: wcg_cfg.svh
`ifndef WCG_CFG_SVH
`define WCG_CFG_SVH

// register indices; byte address is four times the index
`define WCG_IDX_WIDE_DATA    8'h08
`define WCG_IDX_CTL_DATA     8'h09
`define WCG_IDX_WIDE_DIR     8'h88
`define WCG_IDX_CTL_DIR      8'h89
`define WCG_IDX_ANALOG_CFG   8'h9F

// fields of control_direction_slave_status
`define WCG_BIT_IN_FULL      7
`define WCG_BIT_OUT_FULL     6
`define WCG_BIT_IN_OVF       5
`define WCG_BIT_SLAVE_SEL    4

// reset values
`define WCG_RST_WIDE_DIR     8'hFF
`define WCG_RST_CTL_DIR      3'h7
`define WCG_RST_ANALOG_CFG   3'h0
`define WCG_RST_LATCH_WIDE   8'h00
`define WCG_RST_LATCH_CTL    3'h0

// analog_pin_config_field[2:1] value that makes the control pins digital
`define WCG_ACFG_DIGITAL     2'h3

`endif

// file: wcg_pkg.sv
package wcg_pkg;

   // slave-port transfer tracking, one-hot
   typedef enum logic [2:0] {
      WCG_S_IDLE  = 3'b001,
      WCG_S_WRITE = 3'b010,
      WCG_S_READ  = 3'b100
   } wcg_psp_state_t;

endpackage : wcg_pkg

// file: wcg_ports.sv
// Operation
// - eight-bit port, per-pin direction bits
// - mode bit selects slave port or GPIO
// - three-pin port; strobes in slave mode
// - analog control pins read as zero
// - direction bits drive pins even when analog
// - power-on makes control pins analog
// - control direction bit one means input
// - in_buffer_full set on host byte received
// - out_buffer_full set until host reads
// - status register resets to 0000-111
// - host read strobe with select reads latch
// - host write strobe with select captures data
// - deselected chip ignores read and write strobes
// - TTL buffers in slave mode, Schmitt otherwise
// - read returns pins, write updates latch
// - read-modify-write writes whole latch from pins
// - write at cycle end, read at start
// - wide direction resets to all inputs
// - unimplemented bits read as zero
// - overflow set on second write, software clears
// - outside slave mode buffer flags held clear
// - slave mode ignores wide direction register
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`include "wcg_cfg.svh"
module wcg_ports #(
   parameter int ADR_W = 10                         // wishbone byte address width
) (
   input  wire logic                  i_clk_sys,      // 100 MHz system clock
   input  wire logic                  i_sys_rst,      // synchronous reset, active high
   input  wire logic                  i_wb_cyc,       // wishbone cycle
   input  wire logic                  i_wb_stb,       // wishbone strobe
   input  wire logic                  i_wb_we,        // wishbone write enable
   input  wire logic [ADR_W-1:0]      i_wb_adr,       // wishbone byte address
   input  wire logic [31:0]           i_wb_dat,       // wishbone write data
   input  wire logic [3:0]            i_wb_sel,       // wishbone byte selects
   output logic                       o_wb_ack,       // wishbone acknowledge
   output logic [31:0]                o_wb_dat,       // wishbone read data
   input  wire logic [7:0]            i_wide_pin,     // wide port pin levels
   output logic [7:0]                 o_wide_pin,     // wide port drive value
   output logic [7:0]                 o_wide_oe,      // wide port drive enable
   input  wire logic [2:0]            i_ctl_pin,      // control port pin levels
   output logic [2:0]                 o_ctl_pin,      // control port drive value
   output logic [2:0]                 o_ctl_oe,       // control port drive enable
   output logic [2:0]                 o_ctl_analog,   // control pin routed to analog
   output logic                       o_ttl_sel,      // input buffers in TTL mode
   output wcg_pkg::wcg_psp_state_t    o_slave_state   // slave transfer state
);
   import wcg_pkg::*;

   generate
      if (ADR_W < 10) begin : g_chk_adr
         $error("wcg_ports: ADR_W must be at least 10");
      end
   endgenerate

   // pin synchronisers
   logic [7:0] wide_meta;
   logic [7:0] wide_sync;
   logic [2:0] ctl_meta;
   logic [2:0] ctl_sync;

   // software visible state
   logic [7:0] wide_latch;
   logic [7:0] wide_dir;
   logic [2:0] ctl_latch;
   logic [2:0] ctl_dir;
   logic [2:0] analog_cfg;
   logic       slave_sel;
   logic       in_full;
   logic       out_full;
   logic       in_ovf;
   logic [7:0] in_latch;

   // bus
   logic       ack;
   logic [7:0] rdat;
   logic [7:0] next_rdat;
   logic       req;
   logic       commit;
   logic [7:0] idx;

   // slave port
   wcg_psp_state_t state;
   wcg_psp_state_t next_state;
   logic       sel_act;
   logic       host_rd;
   logic       host_wr;
   logic       wr_done;
   logic       rd_start;

   logic       wr_wide;
   logic       wr_ctl;
   logic       wr_wdir;
   logic       wr_cdir;
   logic       wr_acfg;
   logic       cpu_rd_wide;

   // both stages reset to idle levels so strobes look inactive
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         wide_meta <= 8'h00;
         wide_sync <= 8'h00;
         ctl_meta  <= 3'h7;
         ctl_sync  <= 3'h7;
      end else begin
         wide_meta <= i_wide_pin;
         wide_sync <= wide_meta;
         ctl_meta  <= i_ctl_pin;
         ctl_sync  <= ctl_meta;
      end
   end

   assign sel_act = slave_sel & ~ctl_sync[2];
   assign host_rd = sel_act & ~ctl_sync[0];
   assign host_wr = sel_act & ~ctl_sync[1];

   always_comb begin
      next_state = state;
      unique case (state)
         WCG_S_IDLE: begin
            if (host_wr) begin
               next_state = WCG_S_WRITE;
            end else if (host_rd) begin
               next_state = WCG_S_READ;
            end
         end
         WCG_S_WRITE: begin
            if (!host_wr) begin
               next_state = WCG_S_IDLE;
            end
         end
         WCG_S_READ: begin
            if (!host_rd) begin
               next_state = WCG_S_IDLE;
            end
         end
         default: begin
            next_state = WCG_S_IDLE;
         end
      endcase
   end

   // level triggered: the transfer ends when either strobe rises
   assign wr_done  = (state == WCG_S_WRITE) & ~host_wr;
   assign rd_start = (state == WCG_S_IDLE) & ~host_wr & host_rd;

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         state <= WCG_S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // latest sampled byte while the write strobe is low
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         in_latch <= 8'h00;
      end else if (host_wr) begin
         in_latch <= wide_sync;
      end
   end

   // wishbone: ack one cycle after request, read data sampled then
   assign req    = i_wb_cyc & i_wb_stb;
   assign commit = req & ack;
   assign idx    = i_wb_adr[9:2];

   assign wr_wide     = commit & i_wb_we & i_wb_sel[0] & (idx == `WCG_IDX_WIDE_DATA);
   assign wr_ctl      = commit & i_wb_we & i_wb_sel[0] & (idx == `WCG_IDX_CTL_DATA);
   assign wr_wdir     = commit & i_wb_we & i_wb_sel[0] & (idx == `WCG_IDX_WIDE_DIR);
   assign wr_cdir     = commit & i_wb_we & i_wb_sel[0] & (idx == `WCG_IDX_CTL_DIR);
   assign wr_acfg     = commit & i_wb_we & i_wb_sel[0] & (idx == `WCG_IDX_ANALOG_CFG);
   assign cpu_rd_wide = commit & ~i_wb_we & (idx == `WCG_IDX_WIDE_DATA);

   assign o_ctl_analog = (analog_cfg[2:1] == `WCG_ACFG_DIGITAL) ? 3'h0 : 3'h7;

   // reads see the pins, not the output latches (in slave mode the wide port reads in_latch); a read-modify-write
   // therefore rewrites input bits with their sensed level
   always_comb begin
      next_rdat = 8'h00;
      case (idx)
         `WCG_IDX_WIDE_DATA:  next_rdat = slave_sel ? in_latch : wide_sync;
         `WCG_IDX_CTL_DATA:   next_rdat = {5'h00, ctl_sync & ~o_ctl_analog};
         `WCG_IDX_WIDE_DIR:   next_rdat = wide_dir;
         `WCG_IDX_CTL_DIR:    next_rdat = {in_full, out_full, in_ovf, slave_sel, 1'b0, ctl_dir};
         `WCG_IDX_ANALOG_CFG: next_rdat = {5'h00, analog_cfg};
         default:             next_rdat = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         ack  <= 1'b0;
         rdat <= 8'h00;
      end else begin
         ack <= req & ~ack;
         if (req & ~ack) begin
            rdat <= next_rdat;
         end
      end
   end

   assign o_wb_ack = ack;
   assign o_wb_dat = {24'h000000, rdat};

   // writes land on the acknowledge edge, the end of the access
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         wide_latch <= `WCG_RST_LATCH_WIDE;
         ctl_latch  <= `WCG_RST_LATCH_CTL;
      end else begin
         if (wr_wide) begin
            wide_latch <= i_wb_dat[7:0];
         end
         if (wr_ctl) begin
            ctl_latch <= i_wb_dat[2:0];
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         wide_dir   <= `WCG_RST_WIDE_DIR;
         ctl_dir    <= `WCG_RST_CTL_DIR;
         slave_sel  <= 1'b0;
         analog_cfg <= `WCG_RST_ANALOG_CFG;
      end else begin
         if (wr_wdir) begin
            wide_dir <= i_wb_dat[7:0];
         end
         if (wr_cdir) begin
            ctl_dir   <= i_wb_dat[2:0];
            slave_sel <= i_wb_dat[`WCG_BIT_SLAVE_SEL];
         end
         if (wr_acfg) begin
            analog_cfg <= i_wb_dat[2:0];
         end
      end
   end

   // status flags: set beats clear, whether from hardware or software, except that outside slave mode in_full and out_full clear over any set
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         in_full <= 1'b0;
      end else if (!slave_sel) begin
         in_full <= 1'b0;
      end else if (wr_done) begin
         in_full <= 1'b1;
      end else if (cpu_rd_wide) begin
         in_full <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         out_full <= 1'b0;
      end else if (!slave_sel) begin
         out_full <= 1'b0;
      end else if (wr_wide) begin
         out_full <= 1'b1;
      end else if (rd_start) begin
         out_full <= 1'b0;
      end
   end

   // overflow survives leaving slave mode; only software clears it
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         in_ovf <= 1'b0;
      end else if (wr_done & in_full) begin
         in_ovf <= 1'b1;
      end else if (wr_cdir) begin
         in_ovf <= i_wb_dat[`WCG_BIT_IN_OVF];
      end
   end

   // pin drive
   assign o_wide_pin = wide_latch;
   assign o_wide_oe  = slave_sel ? {8{host_rd}} : ~wide_dir;
   assign o_ctl_pin  = ctl_latch;
   // direction still applies to analog pins; strobes are inputs in slave mode
   assign o_ctl_oe   = slave_sel ? 3'h0 : ~ctl_dir;
   assign o_ttl_sel  = slave_sel;
   assign o_slave_state = state;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_sys_rst);

   a_bus_ack_once: assert property (ack |=> !ack)
      else $error("ack held longer than one cycle");
   a_bus_ack_next: assert property (req && !ack |=> ack)
      else $error("request not acknowledged next cycle");
   a_reset_values: assert property ($past(i_sys_rst) |->
         ctl_dir == 3'h7 && wide_dir == 8'hFF && !slave_sel && !in_ovf
         && analog_cfg == 3'h0)
      else $error("register reset value wrong");
   a_in_full_set: assert property (slave_sel && wr_done |=> in_full)
      else $error("in_buffer_full not set after host write");
   a_out_full_clr: assert property (rd_start && !wr_wide |=> !out_full)
      else $error("out_buffer_full not cleared by host read");
   a_ovf_on_second: assert property (wr_done && in_full |=> in_ovf[*2])
      else $error("overflow not set or not sticky");
   a_mode_clears: assert property (!slave_sel && $past(!slave_sel) |->
         !in_full && !out_full)
      else $error("buffer flags set outside slave mode");
   a_wide_drive: assert property (slave_sel |-> o_wide_oe == {8{host_rd}})
      else $error("wide pins driven outside host read");
   a_gpio_dir: assert property (!slave_sel |-> o_wide_oe == ~wide_dir)
      else $error("wide direction not applied");
   a_deselect_idle: assert property (ctl_sync[2] && state == WCG_S_IDLE
         |=> state == WCG_S_IDLE)
      else $error("strobe acted while deselected");
   a_analog_zero: assert property (req && !ack && !i_wb_we
         && idx == `WCG_IDX_CTL_DATA && analog_cfg == 3'h0
         |=> o_wb_dat == 32'h00000000)
      else $error("analog control pin did not read zero");

   c_host_write: cover property (state == WCG_S_WRITE ##[1:20] wr_done);
   c_host_read: cover property (rd_start ##[1:20] state == WCG_S_IDLE);
   c_overflow: cover property ($rose(in_ovf));
   c_cpu_takes_byte: cover property (in_full && cpu_rd_wide);
   c_mode_exit: cover property ($fell(slave_sel));

   // flags: set holds until its own clear; in_full and out_full also clear when slave mode ends
   a_ovf_sticky: assert property (in_ovf && !wr_cdir
         |=> in_ovf)
      else $error("overflow cleared without software write");
   a_in_full_hold: assert property (slave_sel && in_full && !cpu_rd_wide
         |=> in_full)
      else $error("in_buffer_full cleared without cpu read");
   a_out_full_hold: assert property (slave_sel && out_full && !rd_start
         |=> out_full)
      else $error("out_buffer_full cleared without host read");
   a_cpu_read_clr: assert property (slave_sel && cpu_rd_wide && !wr_done
         |=> !in_full)
      else $error("in_buffer_full not cleared by cpu read");

   // host side latch follows the pins only under a selected write
   a_host_capture: assert property (host_wr
         |=> in_latch == $past(wide_sync))
      else $error("host write byte not captured");
   a_latch_hold: assert property (!host_wr
         |=> $stable(in_latch))
      else $error("input latch moved without selected write");
   a_slave_ctl_in: assert property (slave_sel
         |-> o_ctl_oe == 3'h0)
      else $error("control pin driven in slave mode");
   a_ctl_dir_drive: assert property (!slave_sel
         |-> o_ctl_oe == ~ctl_dir)
      else $error("control direction not applied");

   // register side: writes land only on the acknowledge edge
   a_wdir_lands: assert property (wr_wdir
         |=> wide_dir == $past(i_wb_dat[7:0]))
      else $error("direction write did not land");
   a_wdir_hold: assert property (!wr_wdir
         |=> $stable(wide_dir))
      else $error("direction changed without write");
   a_wlatch_lands: assert property (wr_wide
         |=> o_wide_pin == $past(i_wb_dat[7:0]))
      else $error("port latch write did not land");
   a_rdat_stable: assert property (!(req && !ack)
         |=> $stable(o_wb_dat))
      else $error("read data changed without request");
   a_unmapped_zero: assert property (req && !ack && !i_wb_we && idx == 8'h00
         |=> o_wb_dat == 32'h00000000)
      else $error("unmapped register did not read zero");

endmodule : wcg_ports

// file: wcg_host.sv
`timescale 1ns/1ps
module wcg_host (
   input  wire logic       i_clk_sys,  // system clock
   input  wire logic [7:0] i_wide_pin, // device wide drive value
   input  wire logic [7:0] i_wide_oe,  // device wide drive enable
   input  wire logic [2:0] i_ctl_pin,  // device control drive value
   input  wire logic [2:0] i_ctl_oe,   // device control drive enable
   output logic      [7:0] o_wide_lvl, // resolved wide wire levels
   output logic      [2:0] o_ctl_lvl   // resolved control wire levels
);
   logic [7:0] ext_dat = 8'h00;
   logic       ext_oe  = 1'b0;
   logic [2:0] strb_n  = 3'h7;  // cs, wr, rd; pulled up when idle
   logic [7:0] flt     = 8'h55; // undriven wide wires have no pull: toggle
   always @(posedge i_clk_sys) begin
      flt <= ~flt;
   end
   assign o_wide_lvl = (i_wide_oe & i_wide_pin) | (~i_wide_oe & (ext_oe ? ext_dat : flt));
   assign o_ctl_lvl  = (i_ctl_oe & i_ctl_pin) | (~i_ctl_oe & strb_n);
   // one host strobe; data held past the strobe for the synchroniser
   task automatic host_op(input logic cs_n, input logic rd, input logic [7:0] wd,
                          output logic [7:0] rv);
      @(posedge i_clk_sys);
      ext_dat <= wd;
      ext_oe  <= !rd;
      strb_n  <= {cs_n, rd, !rd};
      repeat (6) @(posedge i_clk_sys);
      rv = o_wide_lvl;
      strb_n <= 3'h7;
      repeat (4) @(posedge i_clk_sys);
      ext_oe <= 1'b0;
   endtask : host_op
endmodule : wcg_host

// file: wide_and_control_gpio_ports_tb.sv
`timescale 1ns/1ps
module wide_and_control_gpio_ports_tb;
   import wcg_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        wen = 1'b0;
   logic [9:0]  adr = 10'h000;
   logic [31:0] wdat = 32'h0;
   logic [3:0]  sel = 4'h1;
   logic        ack;
   logic [31:0] rdat;
   logic [7:0]  wpin, woe, wlvl;
   logic [2:0]  cpin, coe, clvl, cana;
   logic        ttl;
   wcg_psp_state_t st;
   int          fails = 0;
   int          n_tests = 0;
   logic [31:0] r;
   logic [7:0]  hv;
   wcg_ports uut (.i_clk_sys(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(wen), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_ack(ack),
      .o_wb_dat(rdat), .i_wide_pin(wlvl), .o_wide_pin(wpin), .o_wide_oe(woe),
      .i_ctl_pin(clvl), .o_ctl_pin(cpin), .o_ctl_oe(coe), .o_ctl_analog(cana),
      .o_ttl_sel(ttl), .o_slave_state(st));
   wcg_host hst (.i_clk_sys(clk), .i_wide_pin(wpin), .i_wide_oe(woe), .i_ctl_pin(cpin),
      .i_ctl_oe(coe), .o_wide_lvl(wlvl), .o_ctl_lvl(clvl));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic print_verdict;
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   // two idle edges after each access keep the pins settled before a read
   task automatic wb(input logic we, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      wen <= we;
      adr <= a;
      wdat <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         fails++;
         $display("unexpected at %0t: bus acknowledge timeout", $time);
      end
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : wb
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(r, {24'h0, e});
   endtask : rd
   task automatic t_reset;
      rd(10'h220, 8'hFF);
      rd(10'h224, 8'h07);
      rd(10'h27C, 8'h00);
      rd(10'h000, 8'h00);
   endtask : t_reset
   task automatic t_wide_gpio;
      wb(1'b1, 10'h220, 8'h0F);
      wb(1'b1, 10'h020, 8'h5A);
      chk(woe, 8'hF0);
      chk(wpin, 8'h5A);
      hst.ext_dat <= 8'hC3;
      hst.ext_oe <= 1'b1;
      repeat (2) @(posedge clk);
      rd(10'h020, 8'h53);
      wb(1'b1, 10'h020, r[7:0] | 8'h80);
      chk(wpin, 8'hD3);
      hst.ext_oe <= 1'b0;
   endtask : t_wide_gpio
   task automatic t_ctl;
      chk(cana, 3'h7);
      rd(10'h024, 8'h00);
      wb(1'b1, 10'h224, 8'h05);
      wb(1'b1, 10'h024, 8'h05);
      chk(coe, 3'h2);
      chk(cpin, 3'h5);
      wb(1'b1, 10'h27C, 8'h06);
      chk(cana, 3'h0);
      rd(10'h024, 8'h05);
      wb(1'b1, 10'h224, 8'h0D);
      rd(10'h224, 8'h05);
   endtask : t_ctl
   task automatic t_slave;
      wb(1'b1, 10'h224, 8'h17);
      chk(ttl, 1'b1);
      wb(1'b1, 10'h020, 8'h3C);
      rd(10'h224, 8'h57);
      hst.host_op(1'b0, 1'b1, 8'h00, hv);
      chk(hv, 8'h3C);
      rd(10'h224, 8'h17);
      chk(woe, 8'h00);
      hst.host_op(1'b0, 1'b0, 8'hA5, hv);
      rd(10'h224, 8'h97);
      hst.host_op(1'b0, 1'b0, 8'h66, hv);
      rd(10'h224, 8'hB7);
      rd(10'h020, 8'h66);
      rd(10'h224, 8'h37);
      hst.host_op(1'b1, 1'b0, 8'h11, hv);
      hst.host_op(1'b1, 1'b1, 8'h00, hv);
      rd(10'h224, 8'h37);
      rd(10'h020, 8'h66);
      chk(st, 3'h1);
      hst.host_op(1'b0, 1'b0, 8'h22, hv);
      rd(10'h224, 8'hB7);
      wb(1'b1, 10'h224, 8'h27);
      rd(10'h224, 8'h27);
      chk(ttl, 1'b0);
      wb(1'b1, 10'h224, 8'h07);
      rd(10'h224, 8'h07);
   endtask : t_slave
   initial begin
      #100us;
      fails++;
      print_verdict();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_wide_gpio();
      t_ctl();
      t_slave();
      print_verdict();
   end
endmodule : wide_and_control_gpio_ports_tb
